// ==== shared/dac_host_pkg.sv ====
// Constants for the serial host that drives a 32-channel output converter.
// Assumes a single 250 MHz system clock and a plain register port of its own.
package dac_host_pkg;

	// Own register port map (byte addresses)
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam logic [ADDR_W-1:0] REG_GO = 8'h00;
	localparam logic [ADDR_W-1:0] REG_FRAME = 8'h04;
	localparam logic [ADDR_W-1:0] REG_STATUS = 8'h08;
	localparam logic [ADDR_W-1:0] REG_RDATA = 8'h0C;

	// Go register bits
	localparam int GO_WRITE_BIT = 0;
	localparam int GO_READ_BIT = 1;

	// Status register bits
	localparam int ST_BUSY = 0;
	localparam int ST_GAP = 1;
	localparam int ST_OVERTEMP = 2;
	localparam int ST_REJECT = 3;

	// Serial frame layout
	localparam int FRAME_BITS = 24;
	localparam int FRAME_MSB = 23;
	localparam int MODE_HI = 23;
	localparam int MODE_LO = 22;
	localparam int ADDR_HI = 21;
	localparam int ADDR_LO = 16;
	localparam int NARROW_PAD_BITS = 2;
	localparam int OVERTEMP_BIT = 4;
	localparam logic [1:0] MODE_SPECIAL = 2'h0;
	localparam logic [23:0] FRAME_NOP = 24'h00_0000;
	localparam logic [23:0] NARROW_MASK = 24'hFF_FFFC;

	// Channel counts per address class
	localparam logic [5:0] CH_ALL = 6'h20;
	localparam logic [5:0] CH_GROUP = 6'h08;
	localparam logic [5:0] CH_FOUR = 6'h04;
	localparam logic [5:0] CH_THREE = 6'h03;
	localparam logic [5:0] CH_ONE = 6'h01;
	localparam logic [2:0] ADDR_CLASS_ALL = 3'h0;
	localparam logic [2:0] ADDR_CLASS_G0123 = 3'h6;
	localparam logic [2:0] ADDR_CLASS_G123 = 3'h7;
	localparam logic [2:0] GROUP_SEL_LAST = 3'h4;

	// Timing
	localparam int SYS_PERIOD_PS = 4000;
	localparam int WR_SCLK_MAX_MHZ = 50;
	localparam int RD_SCLK_MAX_MHZ = 20;
	localparam int CHAN_CALC_NS = 600;
	localparam int WR_HALF_CYCLES =
		(1_000_000 / (2 * WR_SCLK_MAX_MHZ) + SYS_PERIOD_PS - 1) / SYS_PERIOD_PS;
	localparam int RD_HALF_CYCLES =
		(1_000_000 / (2 * RD_SCLK_MAX_MHZ) + SYS_PERIOD_PS - 1) / SYS_PERIOD_PS;
	localparam int CHAN_CALC_CYCLES =
		(CHAN_CALC_NS * 1000 + SYS_PERIOD_PS - 1) / SYS_PERIOD_PS;
	localparam int HALF_W = 4;
	localparam int GAP_W = 13;

	typedef enum logic [2:0] {
		IDLE,
		SETUP,
		LOW,
		HIGH,
		TAIL,
		HOLD
	} link_state_e;

endpackage

// ==== hdl/sclk_tick_gen.sv ====
// Half-period tick generator for the serial clock.
// Assumes run stays high for a whole operation and halfCycles is steady meanwhile.
module sclk_tick_gen
	import dac_host_pkg::*;
#(
	parameter int CNT_W = HALF_W
) (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic run,
	input wire logic [CNT_W-1:0] halfCycles,
	output logic tick
);

	typedef struct packed {
		logic [CNT_W-1:0] cnt;
		logic tick;
	} div_s;

	div_s q;
	div_s d;

	always_comb begin
		d = q;
		d.tick = 1'b0;
		if (!run) begin
			d.cnt = '0;
		end else if (q.cnt == halfCycles - 1'b1) begin
			d.cnt = '0;
			d.tick = 1'b1;
		end else begin
			d.cnt = q.cnt + 1'b1;
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign tick = q.tick;

endmodule

// ==== hdl/dac_serial_host.sv ====
// Serial host that sends 24-bit frames to a 32-channel output converter.
// Assumes the converter samples on falling serial-clock edges and that
// software drives the plain register port on the same clock.
//
// Contract
// - Host keeps serial clock within 50 MHz writes, 20 MHz reads.
// - Frames are 24 bits: mode, six address bits, then data.
// - Narrow variant: two lowest frame bits are zero both ways.
// - Host opens with sync falling, gives 24 falls, then raises sync.
// - No more than 24 falling edges within one frame.
// - With exactly 24 pulses, sync may rise any time afterwards.
// - Commit on sync rising; each new transfer needs sync low again.
// - Read: send mode 00 request, data returns during next transfer.
// - Next write completes no sooner than 600 ns after a write.
// - Multi-channel writes need 600 ns per addressed channel.
//
// Local design decisions: the placing of the registers and the address-and-strobe port.
module dac_serial_host
	import dac_host_pkg::*;
#(
	parameter bit NARROW = 1'b0,
	parameter int GAP_PER_CHAN = CHAN_CALC_CYCLES
) (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic [ADDR_W-1:0] regAddr,
	input wire logic [DATA_W-1:0] regWrData,
	input wire logic regWrite,
	input wire logic regRead,
	output logic [DATA_W-1:0] regRdData,
	output logic serialClk,
	output logic frameSyncN,
	output logic serialIn,
	input wire logic serialOut
);

	typedef struct packed {
		link_state_e st;
		logic sclk;
		logic syncN;
		logic serial_in;
		logic [4:0] bitCnt;
		logic [23:0] tx;
		logic [23:0] rx;
		logic [23:0] frameWord;
		logic [23:0] rdWord;
		logic readOp;
		logic phase2;
		logic calcWrite;
		logic [5:0] chans;
		logic rejected;
		logic [GAP_W-1:0] gap;
		logic sdoMeta;
		logic sdoSync;
		logic [DATA_W-1:0] rdData;
	} host_s;

	host_s q;
	host_s d;
	logic tick;
	logic goHit;

	// Channels touched by one data write, per address class
	function automatic logic [5:0] chanCount(input logic [5:0] a);
		logic [2:0] cls;
		cls = a[5:3];
		if (a == '0) begin
			chanCount = CH_ALL;
		end else if (cls == ADDR_CLASS_ALL) begin
			chanCount = (a[2:0] <= GROUP_SEL_LAST) ? CH_GROUP : CH_ONE;
		end else if (cls == ADDR_CLASS_G0123) begin
			chanCount = CH_FOUR;
		end else if (cls == ADDR_CLASS_G123) begin
			chanCount = CH_THREE;
		end else begin
			chanCount = CH_ONE;
		end
	endfunction

	function automatic logic [GAP_W-1:0] gapFor(input logic [5:0] n);
		gapFor = GAP_W'(32'(n) * GAP_PER_CHAN);
	endfunction

	sclk_tick_gen #(
		.CNT_W(HALF_W)
	) u_tick (
		.sys_clk(sys_clk),
		.reset_n(reset_n),
		.run(q.st != IDLE),
		.halfCycles(q.readOp ? HALF_W'(RD_HALF_CYCLES) : HALF_W'(WR_HALF_CYCLES)),
		.tick(tick)
	);

	assign goHit = regWrite && (regAddr == REG_GO)
		&& (regWrData[GO_WRITE_BIT] || regWrData[GO_READ_BIT]);

	always_comb begin
		d = q;
		d.sdoMeta = serialOut;
		d.sdoSync = q.sdoMeta;
		d.rdData = '0;
		if (q.gap != '0) begin
			d.gap = q.gap - 1'b1;
		end
		if (regRead) begin
			case (regAddr)
				REG_FRAME: d.rdData = DATA_W'(q.frameWord);
				REG_RDATA: d.rdData = DATA_W'(q.rdWord);
				REG_STATUS: begin
					d.rdData[ST_BUSY] = (q.st != IDLE);
					d.rdData[ST_GAP] = (q.gap != '0);
					d.rdData[ST_OVERTEMP] = q.rdWord[OVERTEMP_BIT];
					d.rdData[ST_REJECT] = q.rejected;
				end
				default: d.rdData = '0;
			endcase
		end
		if (regWrite && regAddr == REG_FRAME) begin
			d.frameWord = NARROW ? (regWrData[23:0] & NARROW_MASK) : regWrData[23:0];
		end
		if (regWrite && regAddr == REG_STATUS && regWrData[ST_REJECT]) begin
			d.rejected = 1'b0;
		end
		case (q.st)
			IDLE: begin
				d.sclk = 1'b1;
				d.syncN = 1'b1;
				if (goHit && q.gap == '0) begin
					d.st = SETUP;
					d.syncN = 1'b0;
					d.tx = q.frameWord;
					d.serial_in = q.frameWord[FRAME_MSB];
					d.bitCnt = '0;
					d.readOp = regWrData[GO_READ_BIT] && !regWrData[GO_WRITE_BIT];
					d.phase2 = 1'b0;
					d.calcWrite = (q.frameWord[MODE_HI:MODE_LO] != MODE_SPECIAL);
					d.chans = chanCount(q.frameWord[ADDR_HI:ADDR_LO]);
				end else if (goHit) begin
					d.rejected = 1'b1;
				end
			end
			SETUP, HIGH: begin
				if (tick) begin
					d.sclk = 1'b0;
					d.bitCnt = q.bitCnt + 1'b1;
					d.tx = {q.tx[FRAME_MSB-1:0], 1'b0};
					d.rx = {q.rx[FRAME_MSB-1:0], q.sdoSync};
					d.st = LOW;
				end
			end
			LOW: begin
				if (tick) begin
					d.sclk = 1'b1;
					if (q.bitCnt == 5'(FRAME_BITS)) begin
						d.st = TAIL;
					end else begin
						d.serial_in = q.tx[FRAME_MSB];
						d.st = HIGH;
					end
				end
			end
			TAIL: begin
				if (tick) begin
					d.syncN = 1'b1;
					d.serial_in = 1'b0;
					d.st = HOLD;
					if (q.calcWrite) begin
						d.gap = gapFor(q.chans);
					end
				end
			end
			HOLD: begin
				if (tick) begin
					if (q.readOp && !q.phase2) begin
						d.phase2 = 1'b1;
						d.tx = FRAME_NOP;
						d.calcWrite = 1'b0;
						d.syncN = 1'b0;
						d.serial_in = 1'b0;
						d.bitCnt = '0;
						d.st = SETUP;
					end else begin
						d.st = IDLE;
						if (q.readOp) begin
							d.rdWord = NARROW ? (q.rx & NARROW_MASK) : q.rx;
						end
					end
				end
			end
			default: d.st = IDLE;
		endcase
		if (goHit && q.st != IDLE) begin
			d.rejected = 1'b1;
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			q <= '0;
			q.st <= IDLE;
			q.sclk <= 1'b1;
			q.syncN <= 1'b1;
		end else begin
			q <= d;
		end
	end

	assign regRdData = q.rdData;
	assign serialClk = q.sclk;
	assign frameSyncN = q.syncN;
	assign serialIn = q.serial_in;

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!reset_n);

	full_frame_a: assert property ($rose(frameSyncN) |-> q.bitCnt == 5'd24)
		else $error("frame sync rose without 24 falling edges");
	no_extra_fall_a: assert property ($fell(serialClk) |->
		!frameSyncN && q.bitCnt >= 5'd1 && q.bitCnt <= 5'd24)
		else $error("serial clock fell outside a frame or past 24");
	gated_close_a: assert property ($rose(frameSyncN) |-> serialClk && $past(serialClk))
		else $error("frame sync rose while serial clock was low");
	mode_first_a: assert property ($fell(frameSyncN) && !q.phase2 |->
		serialIn == q.frameWord[23] ##1 serialClk)
		else $error("first frame bit is not the top mode bit");
	narrow_pad_a: assert property (NARROW && !frameSyncN && q.st == HIGH && q.bitCnt >= 5'd22
		|-> !serialIn)
		else $error("narrow pad bits sent nonzero");
	write_rate_a: assert property ($fell(serialClk) |-> !serialClk[*3])
		else $error("serial clock low phase too short");
	read_rate_a: assert property ($fell(serialClk) && q.readOp |-> !serialClk[*7])
		else $error("read serial clock low phase too short");
	sync_gap_a: assert property ($rose(frameSyncN) |-> frameSyncN[*3])
		else $error("frame sync high time too short");
	read_follow_a: assert property ($rose(frameSyncN) && q.readOp && !q.phase2 |->
		##[1:20] $fell(frameSyncN))
		else $error("readback transfer did not follow the request");
	calc_spacing_a: assert property ($fell(frameSyncN) |-> $past(q.gap) <= 13'd1)
		else $error("frame started during calculation spacing");
	gap_load_a: assert property ($rose(frameSyncN) && q.calcWrite |->
		q.gap == gapFor(q.chans) ##1 q.gap == gapFor(q.chans) - 1'b1)
		else $error("calculation spacing not loaded per channel");

	write_done_c: cover property ($rose(frameSyncN) && q.calcWrite);
	read_done_c: cover property ($rose(frameSyncN) && q.phase2);
	all_chan_c: cover property ($rose(frameSyncN) && q.calcWrite && q.chans == CH_ALL);
	rejected_c: cover property ($rose(q.rejected));

endmodule

// ==== tb/dac_device_model.sv ====
// Behavioural model of the converter's serial port and control logic.
// Assumes a host that gates the serial clock and keeps it high outside frames.
module dac_device_model
	import dac_host_pkg::*;
#(
	parameter logic [5:0] CODE_CTRL = 6'h01,
	parameter logic [5:0] CODE_READ = 6'h05,
	parameter logic [5:0] CODE_TOGGLE = 6'h08
) (
	input wire logic serialClk,
	input wire logic frameSyncN,
	input wire logic serialIn,
	output logic serialOut,
	input wire logic hot
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [23:0] shiftReg = '0, rdVal = '0, lastFrame = '0;
	logic [15:0] inA = '0, inB = '0;
	logic [15:0] calcA, calcB, chanOut0;
	logic [7:0] toggleSel [4] = '{default: '0};
	logic [2:0] ctrl = '0;
	logic latched = 1'b0, oe = 1'b0, serial_out = 1'b0, powerDown;
	int bitCount = 0, lastCount = 0;
	realtime commitT = 0, gapNs = 0;
	// Released line shows the inverse of its last level
	assign serialOut = oe ? serial_out : ~serial_out;
	assign powerDown = ctrl[0] | latched;
	// Calculated words follow their input words
	assign calcA = inA;
	assign calcB = inB;
	// Channel 0 output as a load would fill it
	assign chanOut0 = toggleSel[0][0] ? calcB : calcA;
	always @(hot or ctrl) if (ctrl[1] && hot) latched = 1'b1;
	always @(negedge frameSyncN) begin
		bitCount = 0;
		gapNs = $realtime - commitT;
		serial_out = rdVal[23];
	end
	always @(negedge serialClk) if (!frameSyncN) begin
		shiftReg = {shiftReg[22:0], serialIn};
		bitCount++;
	end
	always @(posedge serialClk) if (!frameSyncN && oe) begin
		rdVal = {rdVal[22:0], 1'b0};
		serial_out = rdVal[23];
		if (bitCount >= 24) oe = 1'b0;
	end
	// Short or overlong frames change nothing
	always @(posedge frameSyncN) begin
		lastCount = bitCount;
		if (bitCount == 24) begin
			lastFrame = shiftReg;
			if (shiftReg[23:22] != MODE_SPECIAL) begin
				commitT = $realtime;
				if (shiftReg[23:22] == 2'h3 && ctrl[2]) inB = shiftReg[15:0];
				else if (shiftReg[23:22] == 2'h3) inA = shiftReg[15:0];
			end else if (shiftReg[21:16] == CODE_CTRL) begin
				ctrl = shiftReg[2:0];
				if (!shiftReg[1]) latched = 1'b0;
			end else if (shiftReg[21:16] == CODE_READ) begin
				oe = 1'b1;
				if (shiftReg[2:0] == 3'h0) rdVal = {19'h0, latched, 1'b0, ctrl};
				else rdVal = {16'h0000, toggleSel[2'(shiftReg[2:0] - 3'h1)]};
			end else if (shiftReg[21:18] == CODE_TOGGLE[5:2]) begin
				toggleSel[shiftReg[17:16]] = shiftReg[7:0];
			end
		end
	end
endmodule

// ==== tb/dac_serial_host_test.sv ====
// Self-checking bench for the serial host, driven through its register port.
// Assumes the device model answers on the link; small calc gap for speed.
`define CHK(name, exp, got) \
	begin \
		totalChecks++; \
		if ((got) !== (exp)) begin \
			badCount++; \
			$display("[FAIL] %s expected %0h seen %0h", name, exp, got); \
		end \
	end
module dac_serial_host_test
	import dac_host_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int GAP = 4;
	logic sys_clk = 1'b0, reset_n = 1'b0, regWrite = 1'b0, regRead = 1'b0, hot = 1'b0;
	logic [ADDR_W-1:0] regAddr = '0;
	logic [DATA_W-1:0] regWrData = '0, regRdData, rv;
	logic serialClk, frameSyncN, serialIn, serialOut;
	int badCount = 0, totalChecks = 0;
	logic [7:0] hdr [5] = '{8'hC0, 8'hC1, 8'hB0, 8'h78, 8'h49};
	int chans [5] = '{32, 8, 4, 3, 1};
	always #2 sys_clk = ~sys_clk;
	dac_serial_host #(.NARROW(1'b0), .GAP_PER_CHAN(GAP)) dut (.sys_clk(sys_clk),
		.reset_n(reset_n), .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite),
		.regRead(regRead), .regRdData(regRdData), .serialClk(serialClk),
		.frameSyncN(frameSyncN), .serialIn(serialIn), .serialOut(serialOut));
	dac_device_model model (.serialClk(serialClk), .frameSyncN(frameSyncN),
		.serialIn(serialIn), .serialOut(serialOut), .hot(hot));
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge sys_clk);
		regAddr <= a;
		regWrData <= d;
		regWrite <= 1'b1;
		@(posedge sys_clk);
		regWrite <= 1'b0;
	endtask
	task automatic rd(input logic [ADDR_W-1:0] a);
		@(posedge sys_clk);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge sys_clk);
		regRead <= 1'b0;
		#1 rv = regRdData;
	endtask
	task automatic waitIdle();
		for (int i = 0; i < 3000; i++) begin
			rd(REG_STATUS);
			if (rv[ST_BUSY] === 1'b0 && rv[ST_GAP] === 1'b0) return;
		end
		badCount++;
	endtask
	task automatic send(input logic [23:0] f, input logic [DATA_W-1:0] go);
		wr(REG_FRAME, {8'h00, f});
		wr(REG_GO, go);
		waitIdle();
	endtask
	task automatic wrapUp();
		$display("Checks %0d, mismatches %0d", totalChecks, badCount);
		if (badCount == 0 && totalChecks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	initial begin
		#200us;
		badCount++;
		wrapUp();
	end
	initial begin
		repeat (2) @(posedge sys_clk);
		reset_n <= 1'b1;
		`CHK("idle link", 3'b110, {serialClk, frameSyncN, serialIn})
		rd(REG_STATUS);
		`CHK("status reset", 32'h0000_0000, rv)
		// Every write mode and address class, then spacing
		for (int i = 0; i < 5; i++) begin
			send({hdr[i], 16'h5A30 + 16'(i)}, 32'h0000_0001);
			`CHK("frame", {hdr[i], 16'h5A30 + 16'(i)}, model.lastFrame)
			`CHK("falls", 24, model.lastCount)
			send(24'h01_0000, 32'h0000_0001);
			`CHK("spacing", 1'b1, model.gapNs >= real'(chans[i] * GAP * 4))
		end
		send(24'h01_0004, 32'h0000_0001);
		send(24'hC1_1234, 32'h0000_0001);
		`CHK("bank b", 16'h1234, model.inB)
		// Second start while busy is refused
		wr(REG_FRAME, 32'h00C1_0000);
		wr(REG_GO, 32'h0000_0001);
		wr(REG_GO, 32'h0000_0001);
		rd(REG_STATUS);
		`CHK("reject", 1'b1, rv[ST_REJECT])
		`CHK("busy", 1'b1, rv[ST_BUSY])
		@(posedge sys_clk);
		#1 `CHK("read data drop", 32'h0000_0000, regRdData)
		waitIdle();
		wr(REG_STATUS, 32'h0000_0008);
		rd(REG_STATUS);
		`CHK("reject clear", 1'b0, rv[ST_REJECT])
		rd(REG_FRAME);
		`CHK("frame reg", 32'h00C1_0000, rv)
		rd(8'h10);
		`CHK("unmapped", 32'h0000_0000, rv)
		// Thermal shutdown latches past cooling
		send(24'h01_0002, 32'h0000_0001);
		hot <= 1'b1;
		@(posedge sys_clk);
		hot <= 1'b0;
		`CHK("shutdown", 1'b1, model.powerDown)
		send(24'h05_0000, 32'h0000_0002);
		rd(REG_RDATA);
		`CHK("overtemp", 32'h0000_0012, rv)
		rd(REG_STATUS);
		`CHK("overtemp flag", 1'b1, rv[ST_OVERTEMP])
		send(24'h01_0000, 32'h0000_0001);
		send(24'h05_0000, 32'h0000_0002);
		rd(REG_RDATA);
		`CHK("overtemp cleared", 32'h0000_0000, rv)
		// Toggle-select write and readback
		send(24'h08_005A, 32'h0000_0001);
		send(24'h0B_00C3, 32'h0000_0001);
		send(24'h05_0001, 32'h0000_0002);
		rd(REG_RDATA);
		`CHK("toggle 0", 32'h0000_005A, rv)
		send(24'h05_0004, 32'h0000_0002);
		rd(REG_RDATA);
		`CHK("toggle 3", 32'h0000_00C3, rv)
		`CHK("chan 0 route", 16'h5A31, model.chanOut0)
		wrapUp();
	end
endmodule
